// ===== logic/pc_stack_pkg.sv
// Package: register map, field layout and core operation codes of the program counter and stack
package pc_stack_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int PC_WIDTH      = 21;
  localparam int UPPER_WIDTH   = 5;
  localparam int PTR_WIDTH     = 6;
  localparam int NORMAL_DEPTH  = 31;
  localparam int DEBUG_DEPTH   = 35;

  // ****************************************************************
  // Register byte addresses on the Wishbone bus
  // ****************************************************************
  localparam logic [5:0] ADDR_PC_LOW_BYTE    = 6'h00;
  localparam logic [5:0] ADDR_PC_HIGH_LATCH  = 6'h04;
  localparam logic [5:0] ADDR_PC_UPPER_LATCH = 6'h08;
  localparam logic [5:0] ADDR_STACK_POINTER  = 6'h0C;
  localparam logic [5:0] ADDR_TOS_LOW        = 6'h10;
  localparam logic [5:0] ADDR_TOS_HIGH       = 6'h14;
  localparam logic [5:0] ADDR_TOS_UPPER      = 6'h18;
  localparam logic [5:0] ADDR_POWER_STATUS   = 6'h1C;
  localparam logic [5:0] ADDR_DEBUG_MODE     = 6'h20;

  // ****************************************************************
  // Status field positions (power_control_status)
  // ****************************************************************
  localparam int STAT_FULL_BIT      = 0;
  localparam int STAT_OVERFLOW_BIT  = 1;
  localparam int STAT_UNDERFLOW_BIT = 2;

  // ****************************************************************
  // Reset values and fetch step
  // ****************************************************************
  localparam logic [PC_WIDTH-1:0]  PC_RESET  = 21'h000000;
  localparam logic [PTR_WIDTH-1:0] PTR_RESET = 6'h00;
  localparam logic [1:0]           PC_STEP   = 2'h2;

  // ****************************************************************
  // Core operation request
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_FETCH   = 3'h1,
    OP_CALL    = 3'h2,
    OP_JUMP    = 3'h3,
    OP_RETURN  = 3'h4,
    OP_INT_ACK = 3'h5
  } core_op_e;

  typedef struct packed {
    core_op_e              op;
    logic [PC_WIDTH-1:0]   target;
  } core_req_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [5:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_s;

endpackage

// ===== logic/program_counter_return_stack.sv
// Program counter, latches and hardware return address stack with Wishbone register access
`timescale 1ns/10ps

module program_counter_return_stack #(
  parameter int NORMAL_DEPTH = pc_stack_pkg::NORMAL_DEPTH,
  parameter int DEBUG_DEPTH  = pc_stack_pkg::DEBUG_DEPTH
) (
  input  wire logic                           clock,
  input  wire logic                           rst_b,
  input  wire pc_stack_pkg::wb_req_s          wb_req,
  output pc_stack_pkg::wb_rsp_s               wb_rsp,
  input  wire pc_stack_pkg::core_req_s        core_req,
  output logic [pc_stack_pkg::PC_WIDTH-1:0]   fetch_address
);

  localparam int PW = pc_stack_pkg::PC_WIDTH;
  localparam int AW = pc_stack_pkg::PTR_WIDTH;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [PW-1:0] pc;
    logic [7:0]    pc_high_latch;
    logic [4:0]    pc_upper_latch;
    logic [AW-1:0] stack_pointer_reg;
    logic          full;
    logic          overflow;
    logic          underflow;
    logic          in_circuit_debug_mode;
    logic          ack;
    logic [31:0]   rdata;
  } state_s;

  state_s        cur;
  state_s        nxt;
  logic [PW-1:0] stack_mem [1:DEBUG_DEPTH];
  logic          mem_we;
  logic [AW-1:0] mem_addr;
  logic [PW-1:0] mem_wdata;
  logic [PW-1:0] top_of_stack;

  function automatic logic [AW-1:0] depth_limit(input logic dbg);
    depth_limit = dbg ? AW'(DEBUG_DEPTH) : AW'(NORMAL_DEPTH);
  endfunction

  function automatic logic [PW-1:0] align(input logic [PW-1:0] value);
    align = {value[PW-1:1], 1'b0};
  endfunction

  assign top_of_stack = (cur.stack_pointer_reg == '0) ? '0
                        : stack_mem[cur.stack_pointer_reg];

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic          bus_go;
  logic          bus_wr;
  logic          bus_rd;
  logic [7:0]    wbyte;
  logic [AW-1:0] limit;
  logic [PW-1:0] tos_edit;
  logic          ovf_set;
  logic          unf_set;

  always_comb begin
    nxt       = cur;
    mem_we    = 1'b0;
    mem_addr  = cur.stack_pointer_reg;
    mem_wdata = cur.pc;
    tos_edit  = top_of_stack;
    limit     = depth_limit(cur.in_circuit_debug_mode);
    bus_go    = wb_req.cyc && wb_req.stb && !cur.ack;
    bus_wr    = bus_go && wb_req.we && wb_req.sel[0];
    bus_rd    = bus_go && !wb_req.we;
    wbyte     = wb_req.dat[7:0];
    nxt.ack   = bus_go;
    nxt.rdata = '0;
    ovf_set   = 1'b0;
    unf_set   = 1'b0;

    // Core operations
    case (core_req.op)
      pc_stack_pkg::OP_FETCH: begin
        nxt.pc = align(PW'(cur.pc + PW'(pc_stack_pkg::PC_STEP)));
      end
      pc_stack_pkg::OP_JUMP: begin
        nxt.pc = align(core_req.target);
      end
      pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_INT_ACK: begin
        // Interrupt target comes from the core; latches stay untouched
        nxt.pc = align(core_req.target);
        if (cur.stack_pointer_reg >= limit) begin
          ovf_set = 1'b1;
        end else begin
          nxt.stack_pointer_reg = AW'(cur.stack_pointer_reg + AW'(1));
          mem_we    = 1'b1;
          mem_addr  = nxt.stack_pointer_reg;
          mem_wdata = cur.pc;
        end
      end
      pc_stack_pkg::OP_RETURN: begin
        if (cur.stack_pointer_reg == '0) begin
          unf_set = 1'b1;
        end else begin
          nxt.pc = align(top_of_stack);
          nxt.stack_pointer_reg = AW'(cur.stack_pointer_reg - AW'(1));
        end
      end
      default: begin
      end
    endcase
    nxt.overflow  = cur.overflow || ovf_set;
    nxt.underflow = cur.underflow || unf_set;

    // Register reads
    if (bus_rd) begin
      case (wb_req.adr)
        pc_stack_pkg::ADDR_PC_LOW_BYTE: begin
          nxt.rdata[7:0]     = {cur.pc[7:1], 1'b0};
          nxt.pc_high_latch  = cur.pc[15:8];
          nxt.pc_upper_latch = cur.pc[20:16];
        end
        pc_stack_pkg::ADDR_PC_HIGH_LATCH:  nxt.rdata[7:0] = cur.pc_high_latch;
        pc_stack_pkg::ADDR_PC_UPPER_LATCH: nxt.rdata[4:0] = cur.pc_upper_latch;
        pc_stack_pkg::ADDR_STACK_POINTER:  nxt.rdata[AW-1:0] = cur.stack_pointer_reg;
        pc_stack_pkg::ADDR_TOS_LOW:        nxt.rdata[7:0] = top_of_stack[7:0];
        pc_stack_pkg::ADDR_TOS_HIGH:       nxt.rdata[7:0] = top_of_stack[15:8];
        pc_stack_pkg::ADDR_TOS_UPPER:      nxt.rdata[4:0] = top_of_stack[20:16];
        pc_stack_pkg::ADDR_POWER_STATUS: begin
          nxt.rdata[pc_stack_pkg::STAT_FULL_BIT]      = cur.full;
          nxt.rdata[pc_stack_pkg::STAT_OVERFLOW_BIT]  = cur.overflow;
          nxt.rdata[pc_stack_pkg::STAT_UNDERFLOW_BIT] = cur.underflow;
        end
        pc_stack_pkg::ADDR_DEBUG_MODE:     nxt.rdata[0] = cur.in_circuit_debug_mode;
        default:                           nxt.rdata = '0;
      endcase
    end

    // Register writes; a core update in the same cycle is overridden, except an overflow or underflow flag set by the core
    if (bus_wr) begin
      case (wb_req.adr)
        pc_stack_pkg::ADDR_PC_LOW_BYTE: begin
          nxt.pc = align({cur.pc_upper_latch, cur.pc_high_latch, wbyte});
        end
        pc_stack_pkg::ADDR_PC_HIGH_LATCH:  nxt.pc_high_latch = wbyte;
        pc_stack_pkg::ADDR_PC_UPPER_LATCH: nxt.pc_upper_latch = wbyte[4:0];
        pc_stack_pkg::ADDR_STACK_POINTER: begin
          nxt.stack_pointer_reg = (wbyte[AW-1:0] > limit) ? limit : wbyte[AW-1:0];
        end
        pc_stack_pkg::ADDR_TOS_LOW, pc_stack_pkg::ADDR_TOS_HIGH,
        pc_stack_pkg::ADDR_TOS_UPPER: begin
          if (wb_req.adr == pc_stack_pkg::ADDR_TOS_LOW) begin
            tos_edit[7:0] = wbyte;
          end else if (wb_req.adr == pc_stack_pkg::ADDR_TOS_HIGH) begin
            tos_edit[15:8] = wbyte;
          end else begin
            tos_edit[20:16] = wbyte[4:0];
          end
          if (cur.stack_pointer_reg != '0) begin
            mem_we    = 1'b1;
            mem_addr  = cur.stack_pointer_reg;
            mem_wdata = tos_edit;
          end
        end
        pc_stack_pkg::ADDR_POWER_STATUS: begin
          // Writing zero clears a flag; a hardware set in the same cycle wins
          nxt.overflow  = ovf_set || (cur.overflow && wbyte[1]);
          nxt.underflow = unf_set || (cur.underflow && wbyte[2]);
        end
        pc_stack_pkg::ADDR_DEBUG_MODE: begin
          nxt.in_circuit_debug_mode = wbyte[0];
          if (!wbyte[0] && cur.stack_pointer_reg > AW'(NORMAL_DEPTH)) begin
            nxt.stack_pointer_reg = AW'(NORMAL_DEPTH);
          end
        end
        default: begin
        end
      endcase
    end

    nxt.full = (nxt.stack_pointer_reg >= depth_limit(nxt.in_circuit_debug_mode));
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '{pc: pc_stack_pkg::PC_RESET, stack_pointer_reg: pc_stack_pkg::PTR_RESET,
               default: '0};
    end else begin
      cur <= nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (mem_we && mem_addr != '0) begin
      stack_mem[mem_addr] <= mem_wdata;
    end
  end

  always_comb begin
    wb_rsp.ack    = cur.ack;
    wb_rsp.dat    = cur.rdata;
    fetch_address = cur.pc;
  end

endmodule // program_counter_return_stack

// ===== testbench/pc_stack_monitor.sv
// Checker of bus answers and program counter updates
`timescale 1ns/10ps
module pc_stack_monitor (
  input wire logic                               clock,
  input wire logic                               rst_b,
  input wire pc_stack_pkg::wb_req_s              wb_req,
  input wire pc_stack_pkg::wb_rsp_s              wb_rsp,
  input wire pc_stack_pkg::core_req_s            core_req,
  input wire logic [pc_stack_pkg::PC_WIDTH-1:0]  fetch_address
);
  logic take;
  logic pc_wr;
  assign take  = wb_req.cyc & wb_req.stb & !wb_rsp.ack;
  assign pc_wr = take & wb_req.we & wb_req.sel[0] &
                 (wb_req.adr == pc_stack_pkg::ADDR_PC_LOW_BYTE);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  ack_follows_req_a: assert property (take |=> wb_rsp.ack)
    else $error("bus request not answered");
  ack_one_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack longer than one cycle");
  rdata_idle_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0)
    else $error("read data without ack");
  pc_aligned_a: assert property (fetch_address[0] == 1'b0)
    else $error("program counter odd");
  fetch_step_a: assert property (core_req.op == pc_stack_pkg::OP_FETCH && !pc_wr
    |=> fetch_address == $past(fetch_address) + 21'h2) else $error("fetch step wrong");
  jump_direct_a: assert property (core_req.op inside {pc_stack_pkg::OP_JUMP,
    pc_stack_pkg::OP_CALL, pc_stack_pkg::OP_INT_ACK} && !pc_wr
    |=> fetch_address == {$past(core_req.target[20:1]), 1'b0}) else $error("jump wrong");
  pc_write_low_a: assert property (pc_wr
    |=> fetch_address[7:0] == {$past(wb_req.dat[7:1]), 1'b0}) else $error("low write wrong");
  call_return_a: assert property ((core_req.op == pc_stack_pkg::OP_CALL && !pc_wr)
    ##1 (core_req.op == pc_stack_pkg::OP_RETURN && !pc_wr)
    |=> fetch_address == $past(fetch_address, 2)) else $error("return address wrong");
endmodule // pc_stack_monitor

bind program_counter_return_stack pc_stack_monitor u_mon (.clock(clock), .rst_b(rst_b),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .core_req(core_req), .fetch_address(fetch_address));

// ===== testbench/core_model.sv
// Behavioural core that issues fetch, jump, call and return requests
`timescale 1ns/10ps
module core_model (
  input wire logic                  clock,
  output pc_stack_pkg::core_req_s   core_req
);
  initial core_req = '{pc_stack_pkg::OP_NONE, 21'h0};
  // One request per edge, held until the next call
  task automatic issue(input pc_stack_pkg::core_op_e op, input logic [20:0] target);
    @(posedge clock);
    core_req <= '{op, target};
  endtask
endmodule // core_model

// ===== testbench/program_counter_return_stack_tb.sv
// Self-checking bench of the program counter and return stack
`timescale 1ns/10ps
module program_counter_return_stack_tb;
  logic                     clock;
  logic                     rst_b;
  pc_stack_pkg::wb_req_s    wb_req;
  pc_stack_pkg::wb_rsp_s    wb_rsp;
  pc_stack_pkg::core_req_s  core_req;
  logic [20:0]              fetch_address;
  logic [31:0]              rd;
  int                       n_tests;
  int                       miscompares;
  program_counter_return_stack u_dut (.clock(clock), .rst_b(rst_b), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .core_req(core_req), .fetch_address(fetch_address));
  core_model u_core (.clock(clock), .core_req(core_req));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic conclude;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] adr, input logic [7:0] dat);
    int i;
    @(posedge clock);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, dat}};
    for (i = 0; i < 20 && wb_rsp.ack !== 1'b1; i++) @(posedge clock);
    if (wb_rsp.ack !== 1'b1) begin
      miscompares++;
      conclude();
    end else begin
      rd = wb_rsp.dat;
      wb_req <= '0;
    end
  endtask
  task automatic rchk(input string what, input logic [5:0] adr, input logic [7:0] exp);
    wb(1'b0, adr, 8'h00);
    check(what, rd, {24'h0, exp});
  endtask
  task automatic pc_is(input string what, input logic [20:0] exp);
    u_core.issue(pc_stack_pkg::OP_NONE, 21'h0);
    @(negedge clock);
    check(what, {11'h0, fetch_address}, {11'h0, exp});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rchk("pointer", pc_stack_pkg::ADDR_STACK_POINTER, 8'h00);
    rchk("status", pc_stack_pkg::ADDR_POWER_STATUS, 8'h00);
    rchk("tos zero", pc_stack_pkg::ADDR_TOS_LOW, 8'h00);
    rchk("unmapped", 6'h3C, 8'h00);
    pc_is("reset pc", 21'h0);
  endtask
  task automatic t_fetch;
    repeat (3) u_core.issue(pc_stack_pkg::OP_FETCH, 21'h0);
    pc_is("fetch", 21'h6);
  endtask
  task automatic t_latch;
    wb(1'b1, pc_stack_pkg::ADDR_PC_HIGH_LATCH, 8'h12);
    wb(1'b1, pc_stack_pkg::ADDR_PC_UPPER_LATCH, 8'hFF);
    rchk("upper latch", pc_stack_pkg::ADDR_PC_UPPER_LATCH, 8'h1F);
    wb(1'b1, pc_stack_pkg::ADDR_PC_LOW_BYTE, 8'h35);
    pc_is("low write", 21'h1F1234);
    u_core.issue(pc_stack_pkg::OP_JUMP, 21'h0ABCDF);
    pc_is("jump", 21'h0ABCDE);
    rchk("pc low", pc_stack_pkg::ADDR_PC_LOW_BYTE, 8'hDE);
    rchk("high copy", pc_stack_pkg::ADDR_PC_HIGH_LATCH, 8'hBC);
    rchk("upper copy", pc_stack_pkg::ADDR_PC_UPPER_LATCH, 8'h0A);
  endtask
  task automatic t_call;
    wb(1'b1, pc_stack_pkg::ADDR_PC_HIGH_LATCH, 8'h77);
    u_core.issue(pc_stack_pkg::OP_CALL, 21'h001000);
    u_core.issue(pc_stack_pkg::OP_RETURN, 21'h0);
    pc_is("call return", 21'h0ABCDE);
    u_core.issue(pc_stack_pkg::OP_INT_ACK, 21'h000008);
    pc_is("vector", 21'h8);
    // Core stays quiet while the stack top is touched
    rchk("tos upper", pc_stack_pkg::ADDR_TOS_UPPER, 8'h0A);
    rchk("tos high", pc_stack_pkg::ADDR_TOS_HIGH, 8'hBC);
    rchk("tos low", pc_stack_pkg::ADDR_TOS_LOW, 8'hDE);
    rchk("pointer", pc_stack_pkg::ADDR_STACK_POINTER, 8'h01);
    rchk("latch kept", pc_stack_pkg::ADDR_PC_HIGH_LATCH, 8'h77);
    wb(1'b1, pc_stack_pkg::ADDR_TOS_UPPER, 8'h01);
    wb(1'b1, pc_stack_pkg::ADDR_TOS_HIGH, 8'h23);
    wb(1'b1, pc_stack_pkg::ADDR_TOS_LOW, 8'h56);
    u_core.issue(pc_stack_pkg::OP_RETURN, 21'h0);
    pc_is("tos return", 21'h012356);
    rchk("popped", pc_stack_pkg::ADDR_STACK_POINTER, 8'h00);
  endtask
  task automatic t_limits;
    wb(1'b1, pc_stack_pkg::ADDR_STACK_POINTER, 8'h3F);
    rchk("clamp", pc_stack_pkg::ADDR_STACK_POINTER, 8'h1F);
    rchk("full", pc_stack_pkg::ADDR_POWER_STATUS, 8'h01);
    u_core.issue(pc_stack_pkg::OP_CALL, 21'h000100);
    pc_is("overflow jump", 21'h100);
    rchk("overflow", pc_stack_pkg::ADDR_POWER_STATUS, 8'h03);
    rchk("no push", pc_stack_pkg::ADDR_STACK_POINTER, 8'h1F);
    wb(1'b1, pc_stack_pkg::ADDR_POWER_STATUS, 8'h00);
    rchk("cleared", pc_stack_pkg::ADDR_POWER_STATUS, 8'h01);
    wb(1'b1, pc_stack_pkg::ADDR_STACK_POINTER, 8'h00);
    u_core.issue(pc_stack_pkg::OP_RETURN, 21'h0);
    pc_is("underflow pc", 21'h100);
    rchk("underflow", pc_stack_pkg::ADDR_POWER_STATUS, 8'h04);
    wb(1'b1, pc_stack_pkg::ADDR_POWER_STATUS, 8'h00);
  endtask
  task automatic t_debug;
    wb(1'b1, pc_stack_pkg::ADDR_DEBUG_MODE, 8'h01);
    wb(1'b1, pc_stack_pkg::ADDR_STACK_POINTER, 8'h23);
    rchk("debug ptr", pc_stack_pkg::ADDR_STACK_POINTER, 8'h23);
    rchk("debug full", pc_stack_pkg::ADDR_POWER_STATUS, 8'h01);
    wb(1'b1, pc_stack_pkg::ADDR_DEBUG_MODE, 8'h00);
    rchk("leave debug", pc_stack_pkg::ADDR_STACK_POINTER, 8'h1F);
  endtask
  initial begin
    n_tests = 0;
    miscompares = 0;
    rst_b = 1'b0;
    wb_req = '0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    t_reset();
    t_fetch();
    t_latch();
    t_call();
    t_limits();
    t_debug();
    conclude();
  end
endmodule // program_counter_return_stack_tb
